/* File: core/slm_pkg.sv */
// constants and types shared by the supply-loss monitor files
package slm_pkg;
	// ****************************************
	// bus addresses and register offsets
	// ****************************************
	localparam logic [6:0] I2C_SET_ADDR = 7'h6B;
	localparam logic [6:0] I2C_MON_ADDR = 7'h69;
	localparam logic [7:0] OFS_SPK_DUR  = 8'h1A;
	localparam logic [7:0] OFS_CMP_SEL  = 8'h1B;
	localparam logic [7:0] OFS_DROP     = 8'h1C;
	localparam logic [7:0] OFS_TRIP_LO  = 8'h02;
	localparam logic [7:0] OFS_TRIP_HI  = 8'h03;
	localparam logic [7:0] OFS_SWC_LO   = 8'h04;
	localparam logic [7:0] OFS_SWC_HI   = 8'h05;
	// ****************************************
	// reset values and codes
	// ****************************************
	localparam logic [7:0] RST_SPK_DUR  = 8'h19;
	localparam logic [7:0] RST_CMP_SEL  = 8'h02;
	localparam logic [7:0] RST_DROP     = 8'h03;
	localparam logic [7:0] SEL_OFF      = 8'h00;
	localparam logic [7:0] SEL_4918     = 8'h01;
	localparam logic [7:0] SEL_4645     = 8'h02;
	localparam logic [7:0] SEL_4372     = 8'h03;
	localparam logic [7:0] DROP_MIN     = 8'h01;
	localparam logic [7:0] DROP_MAX     = 8'h09;
	// ****************************************
	// voltages in mV
	// ****************************************
	localparam logic [15:0] TH_4918_MV  = 16'h1336;
	localparam logic [15:0] TH_4645_MV  = 16'h1225;
	localparam logic [15:0] TH_4372_MV  = 16'h1114;
	localparam logic [15:0] TH_4096_MV  = 16'h1000;
	localparam logic [15:0] DROP_STEP_MV = 16'h0064;
	localparam logic [15:0] MV_PER_UNIT = 16'h000A;
	// ****************************************
	// timing
	// ****************************************
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          GAP_STEP_NS   = 10000;
	localparam int          TICK_CYC      = GAP_STEP_NS / CLK_PERIOD_NS;
	localparam logic [11:0] TICK_LAST     = 12'(TICK_CYC - 1);
	// ****************************************
	// state types
	// ****************************************
	typedef enum logic [1:0] {
		MON_OFF   = 2'b00,
		MON_IDLE  = 2'b01,
		MON_WATCH = 2'b10,
		MON_BATT  = 2'b11
	} slm_mon_type;
	typedef enum logic [2:0] {
		I2C_IDLE  = 3'b000,
		I2C_ADDR  = 3'b001,
		I2C_ACKA  = 3'b010,
		I2C_WRITE = 3'b011,
		I2C_ACKW  = 3'b100,
		I2C_READ  = 3'b101,
		I2C_ACKR  = 3'b110
	} slm_i2c_type;
endpackage

/* File: core/slm_gap_timer.sv */
// gap-duration filter timer, counts 10 us steps while a gap is watched
`timescale 1ns/1ps
module slm_gap_timer (
	input  wire logic       clk_i,     // system clock
	input  wire logic       resetn_i,  // sync reset, active low
	input  wire logic       run_i,     // gap being watched
	input  wire logic [7:0] dur_i,     // window in 10 us steps
	output logic            expired_o  // window elapsed
);
	import slm_pkg::*;
	logic [11:0] pre;
	logic [7:0]  ticks;
	logic [11:0] next_pre;
	logic [7:0]  next_ticks;
	logic        next_expired;

	always_comb begin
		next_pre   = pre;
		next_ticks = ticks;
		if (!run_i) begin
			next_pre   = 12'h000;
			next_ticks = 8'h00;
		end else if (pre == TICK_LAST) begin
			next_pre = 12'h000;
			if (ticks != 8'hFF) begin
				next_ticks = ticks + 8'h01;
			end
		end else begin
			next_pre = pre + 12'h001;
		end
		next_expired = run_i && (next_ticks >= dur_i);
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pre       <= 12'h000;
			ticks     <= 8'h00;
			expired_o <= 1'b0;
		end else begin
			pre       <= next_pre;
			ticks     <= next_ticks;
			expired_o <= next_expired;
		end
	end
endmodule

/* File: core/slm_i2c_slave.sv */
// byte-level i2c target answering on the settings and monitoring addresses
`timescale 1ns/1ps
module slm_i2c_slave (
	input  wire logic       clk_i,     // system clock
	input  wire logic       resetn_i,  // sync reset, active low
	input  wire logic       scl_i,     // synchronised scl
	input  wire logic       sda_i,     // synchronised sda
	input  wire logic [7:0] rd_data_i, // byte at ptr_o
	output logic            sda_oen_o, // low = pull sda low
	output logic            bank_o,    // 1 = settings address
	output logic [7:0]      ptr_o,     // register pointer
	output logic            wr_stb_o,  // write pulse
	output logic [7:0]      wr_addr_o, // write offset
	output logic [7:0]      wr_data_o  // write data
);
	import slm_pkg::*;
	slm_i2c_type st, next_st;
	logic       scl_q, sda_q, rw, first, nack;
	logic [3:0] bitc;
	logic [7:0] sh;
	logic       next_rw, next_first, next_nack, next_oen, next_bank, next_stb;
	logic [3:0] next_bitc;
	logic [7:0] next_sh, next_ptr, next_waddr, next_wdata;
	logic       rise, fall, start, stop;

	assign rise  = scl_i && !scl_q;
	assign fall  = !scl_i && scl_q;
	assign start = scl_i && scl_q && sda_q && !sda_i;
	assign stop  = scl_i && scl_q && !sda_q && sda_i;

	always_comb begin
		next_st    = st;
		next_rw    = rw;
		next_first = first;
		next_nack  = nack;
		next_oen   = sda_oen_o;
		next_bank  = bank_o;
		next_stb   = 1'b0;
		next_bitc  = bitc;
		next_sh    = sh;
		next_ptr   = ptr_o;
		next_waddr = wr_addr_o;
		next_wdata = wr_data_o;
		if (start) begin
			next_st   = I2C_ADDR;
			next_bitc = 4'h0;
			next_oen  = 1'b1;
		end else if (stop) begin
			next_st  = I2C_IDLE;
			next_oen = 1'b1;
		end else if (rise && (st == I2C_ADDR || st == I2C_WRITE)) begin
			next_sh   = {sh[6:0], sda_i};
			next_bitc = bitc + 4'h1;
		end else if (rise && st == I2C_ACKR) begin
			next_nack = sda_i;
		end else if (fall) begin
			case (st)
				I2C_ADDR: if (bitc == 4'h8) begin
					if (sh[7:1] == I2C_SET_ADDR || sh[7:1] == I2C_MON_ADDR) begin
						next_bank = (sh[7:1] == I2C_SET_ADDR);
						next_rw   = sh[0];
						next_oen  = 1'b0;
						next_st   = I2C_ACKA;
					end else begin
						next_st = I2C_IDLE;
					end
				end
				I2C_ACKA: begin
					next_bitc = 4'h0;
					if (rw) begin
						next_sh  = rd_data_i;
						next_oen = rd_data_i[7];
						next_st  = I2C_READ;
					end else begin
						next_oen   = 1'b1;
						next_first = 1'b1;
						next_st    = I2C_WRITE;
					end
				end
				I2C_WRITE: if (bitc == 4'h8) begin
					next_oen   = 1'b0;
					next_st    = I2C_ACKW;
					next_first = 1'b0;
					if (first) begin
						next_ptr = sh;
					end else begin
						next_stb   = 1'b1;
						next_waddr = ptr_o;
						next_wdata = sh;
						next_ptr   = ptr_o + 8'h01;
					end
				end
				I2C_ACKW: begin
					next_oen  = 1'b1;
					next_bitc = 4'h0;
					next_st   = I2C_WRITE;
				end
				I2C_READ: begin
					if (bitc == 4'h7) begin
						next_oen = 1'b1;
						next_st  = I2C_ACKR;
						next_ptr = ptr_o + 8'h01;
					end else begin
						next_sh   = {sh[6:0], 1'b0};
						next_oen  = sh[6];
						next_bitc = bitc + 4'h1;
					end
				end
				I2C_ACKR: begin
					// a nack from the host ends the read burst
					if (nack) begin
						next_st = I2C_IDLE;
					end else begin
						next_sh   = rd_data_i;
						next_oen  = rd_data_i[7];
						next_bitc = 4'h0;
						next_st   = I2C_READ;
					end
				end
				default: next_st = I2C_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st        <= I2C_IDLE;
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			rw        <= 1'b0;
			first     <= 1'b0;
			nack      <= 1'b0;
			bitc      <= 4'h0;
			sh        <= 8'h00;
			sda_oen_o <= 1'b1;
			bank_o    <= 1'b0;
			ptr_o     <= 8'h00;
			wr_stb_o  <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 8'h00;
		end else begin
			st        <= next_st;
			scl_q     <= scl_i;
			sda_q     <= sda_i;
			rw        <= next_rw;
			first     <= next_first;
			nack      <= next_nack;
			bitc      <= next_bitc;
			sh        <= next_sh;
			sda_oen_o <= next_oen;
			bank_o    <= next_bank;
			ptr_o     <= next_ptr;
			wr_stb_o  <= next_stb;
			wr_addr_o <= next_waddr;
			wr_data_o <= next_wdata;
		end
	end
endmodule

/* File: core/slm_monitor.sv */
// supply-loss monitor top: settings, trip/switch decision, level capture
// Operation
// - code 0x01 trips the comparator below 4.918 V.
// - code 0x02 trips below 4.645 V and is the reset selection.
// - code 0x03 trips the comparator below 4.372 V.
// - code 0x04 trips the comparator below 4.096 V.
// - a trip only starts monitoring, never switches to battery directly.
// - after a trip, a further programmed drop (0.1-0.9 V) switches to battery.
// - battery engages on gap window expiry or extra drop, whichever first.
// - drop amount resets to 0x03, meaning 0.3 V.
// - short gaps staying above threshold minus drop are rejected.
// - gap window counts 10 us steps, so 0xff is a long window.
// - supply at trip is kept as a 16-bit 10 mV word at 0x02.
// - supply at switch-over is kept as a 16-bit 10 mV word at 0x04.
// - with backup disabled, the clock stops at once and cable loss stops the host.
// - disabling backup leaves relay, converter, buzzer and leds working.
// - gap duration resets to 25, a 250 us window.
// - code 0x00 disables monitoring and disconnects the battery.
`timescale 1ns/1ps
module slm_monitor (
	input  wire logic        clk_i,        // system clock, 250 MHz
	input  wire logic        resetn_i,     // sync reset, active low
	input  wire logic [15:0] supply_mv_i,  // supply sample in mV, same clock
	input  wire logic        scl_i,        // i2c clock pin
	input  wire logic        sda_i,        // i2c data pin level
	output logic             sda_o,        // i2c data drive value
	output logic             sda_oen_o,    // low while pulling sda
	output logic             batt_on_o,    // running from battery
	output logic             batt_conn_o,  // battery connected
	output logic             host_pwr_o,   // host powered
	output logic             rtc_run_o,    // real-time clock runs
	output logic             periph_en_o,  // relay, converter, buzzer, leds
	output logic             watching_o    // gap being filtered
);
	import slm_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] thr_of(input logic [7:0] sel);
		case (sel)
			SEL_4918: thr_of = TH_4918_MV;
			SEL_4645: thr_of = TH_4645_MV;
			SEL_4372: thr_of = TH_4372_MV;
			default:  thr_of = TH_4096_MV;
		endcase
	endfunction

	function automatic logic [15:0] drop_of(input logic [7:0] code);
		logic [7:0] c;
		c = code;
		// out-of-range codes clamp so the cut level never underflows
		if (c < DROP_MIN) begin
			c = DROP_MIN;
		end else if (c > DROP_MAX) begin
			c = DROP_MAX;
		end
		drop_of = 16'(c * DROP_STEP_MV);
	endfunction

	function automatic logic [15:0] to_units(input logic [15:0] mv);
		to_units = mv / MV_PER_UNIT;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic scl_meta, scl_sync, sda_meta, sda_sync;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			scl_meta <= 1'b1;
			scl_sync <= 1'b1;
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
		end else begin
			scl_meta <= scl_i;
			scl_sync <= scl_meta;
			sda_meta <= sda_i;
			sda_sync <= sda_meta;
		end
	end

	// ****************************************
	// i2c target and registers
	// ****************************************
	logic       bank, wr_stb;
	logic [7:0] ptr, wr_addr, wr_data, rd_byte;
	logic [7:0] spk_dur, cmp_sel, switchover_drop_amount;
	logic [7:0] next_spk_dur, next_cmp_sel, next_switchover_drop_amount;
	logic [15:0] trip_lvl, swc_lvl;

	slm_i2c_slave u_i2c (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.scl_i     (scl_sync),
		.sda_i     (sda_sync),
		.rd_data_i (rd_byte),
		.sda_oen_o (sda_oen_o),
		.bank_o    (bank),
		.ptr_o     (ptr),
		.wr_stb_o  (wr_stb),
		.wr_addr_o (wr_addr),
		.wr_data_o (wr_data)
	);

	always_comb begin
		rd_byte = 8'h00;
		if (bank) begin
			case (ptr)
				OFS_SPK_DUR: rd_byte = spk_dur;
				OFS_CMP_SEL: rd_byte = cmp_sel;
				OFS_DROP:    rd_byte = switchover_drop_amount;
				default:     rd_byte = 8'h00;
			endcase
		end else begin
			// word reads are little-endian, low byte first
			case (ptr)
				OFS_TRIP_LO: rd_byte = trip_lvl[7:0];
				OFS_TRIP_HI: rd_byte = trip_lvl[15:8];
				OFS_SWC_LO:  rd_byte = swc_lvl[7:0];
				OFS_SWC_HI:  rd_byte = swc_lvl[15:8];
				default:     rd_byte = 8'h00;
			endcase
		end
	end

	always_comb begin
		next_spk_dur                = spk_dur;
		next_cmp_sel                = cmp_sel;
		next_switchover_drop_amount = switchover_drop_amount;
		// monitoring bank is read-only; writes there are dropped
		if (wr_stb && bank) begin
			case (wr_addr)
				OFS_SPK_DUR: next_spk_dur = wr_data;
				OFS_CMP_SEL: next_cmp_sel = wr_data;
				OFS_DROP:    next_switchover_drop_amount = wr_data;
				default:     next_switchover_drop_amount = switchover_drop_amount;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			spk_dur                <= RST_SPK_DUR;
			cmp_sel                <= RST_CMP_SEL;
			switchover_drop_amount <= RST_DROP;
		end else begin
			spk_dur                <= next_spk_dur;
			cmp_sel                <= next_cmp_sel;
			switchover_drop_amount <= next_switchover_drop_amount;
		end
	end

	// ****************************************
	// monitoring algorithm
	// ****************************************
	slm_mon_type st, next_st;
	logic [15:0] thr_mv, cut_mv, next_trip, next_swc;
	logic        below_thr, below_cut, gap_exp;
	logic        next_batt_on, next_conn, next_host;

	assign thr_mv    = thr_of(cmp_sel);
	assign cut_mv    = thr_mv - drop_of(switchover_drop_amount);
	assign below_thr = supply_mv_i < thr_mv;
	assign below_cut = supply_mv_i < cut_mv;

	slm_gap_timer u_gap (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.run_i     (st == MON_WATCH),
		.dur_i     (spk_dur),
		.expired_o (gap_exp)
	);

	always_comb begin
		next_st   = st;
		next_trip = trip_lvl;
		next_swc  = swc_lvl;
		case (st)
			MON_OFF: begin
				next_st = MON_IDLE;
			end
			MON_IDLE: begin
				if (below_thr) begin
					next_st   = MON_WATCH;
					next_trip = to_units(supply_mv_i);
				end
			end
			MON_WATCH: begin
				if (!below_thr) begin
					next_st = MON_IDLE;
				end else if (below_cut || gap_exp) begin
					next_st  = MON_BATT;
					next_swc = to_units(supply_mv_i);
				end
			end
			MON_BATT: begin
				if (!below_thr) begin
					next_st = MON_IDLE;
				end
			end
			default: next_st = MON_OFF;
		endcase
		if (cmp_sel == SEL_OFF) begin
			next_st = MON_OFF;
		end
	end

	always_comb begin
		next_batt_on = (next_st == MON_BATT);
		next_conn    = (next_st != MON_OFF);
		// without backup the host lives only while cable power holds
		next_host    = (next_st != MON_OFF) || !(supply_mv_i < TH_4096_MV);
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st          <= MON_IDLE;
			trip_lvl    <= 16'h0000;
			swc_lvl     <= 16'h0000;
			batt_on_o   <= 1'b0;
			batt_conn_o <= 1'b1;
			host_pwr_o  <= 1'b1;
			rtc_run_o   <= 1'b1;
			watching_o  <= 1'b0;
			periph_en_o <= 1'b0;
			sda_o       <= 1'b0;
		end else begin
			st          <= next_st;
			trip_lvl    <= next_trip;
			swc_lvl     <= next_swc;
			batt_on_o   <= next_batt_on;
			batt_conn_o <= next_conn;
			host_pwr_o  <= next_host;
			rtc_run_o   <= next_conn && next_host;
			watching_o  <= (next_st == MON_WATCH);
			periph_en_o <= 1'b1;
			sda_o       <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	property p_thr_sel;
		(cmp_sel == SEL_4918) |-> (thr_mv == TH_4918_MV);
	endproperty
	a_thr_sel: assert property (p_thr_sel) else $error("code 1 threshold wrong");

	property p_reset_vals;
		!$past(resetn_i) |-> (cmp_sel == RST_CMP_SEL && switchover_drop_amount == RST_DROP
			&& spk_dur == RST_SPK_DUR);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	property p_trip_watch;
		(st == MON_IDLE && below_thr && cmp_sel != SEL_OFF) |=> (st == MON_WATCH);
	endproperty
	a_trip_watch: assert property (p_trip_watch) else $error("trip did not watch");

	property p_no_direct;
		$rose(batt_on_o) |-> ($past(st) == MON_WATCH);
	endproperty
	a_no_direct: assert property (p_no_direct) else $error("battery without watch");

	property p_drop_switch;
		(st == MON_WATCH && below_cut && cmp_sel != SEL_OFF) |=> batt_on_o;
	endproperty
	a_drop_switch: assert property (p_drop_switch) else $error("drop not switched");

	property p_exp_switch;
		(st == MON_WATCH && below_thr && gap_exp && cmp_sel != SEL_OFF) |=> batt_on_o;
	endproperty
	a_exp_switch: assert property (p_exp_switch) else $error("expiry not switched");

	property p_reject;
		(st == MON_WATCH && !below_thr && cmp_sel != SEL_OFF) |=> (st == MON_IDLE);
	endproperty
	a_reject: assert property (p_reject) else $error("gap not rejected");

	property p_trip_cap;
		(st == MON_IDLE && below_thr && cmp_sel != SEL_OFF)
			|=> (trip_lvl == to_units($past(supply_mv_i)));
	endproperty
	a_trip_cap: assert property (p_trip_cap) else $error("trip level not kept");

	property p_swc_cap;
		$rose(batt_on_o) |-> (swc_lvl == to_units($past(supply_mv_i)));
	endproperty
	a_swc_cap: assert property (p_swc_cap) else $error("switch level not kept");

	property p_disable;
		(cmp_sel == SEL_OFF) |=> (!batt_conn_o && !batt_on_o);
	endproperty
	a_disable: assert property (p_disable) else $error("battery not cut off");

	property p_host_stop;
		(cmp_sel == SEL_OFF && supply_mv_i < TH_4096_MV) |=> (!host_pwr_o && !rtc_run_o);
	endproperty
	a_host_stop: assert property (p_host_stop) else $error("host kept running");

	c_reject: cover property (st == MON_WATCH ##1 st == MON_IDLE);
	c_expire: cover property (st == MON_WATCH && gap_exp ##1 st == MON_BATT);
	c_drop:   cover property (st == MON_WATCH && below_cut && !gap_exp ##1 st == MON_BATT);
	c_off:    cover property (st == MON_OFF);
endmodule

/* File: sim/slm_i2c_host.sv */
// i2c host model standing in for the single-board computer
`timescale 1ns/1ps
module slm_i2c_host (
	input  wire logic clk_i,     // system clock
	input  wire logic sda_i,     // resolved sda wire
	output logic      scl_o,     // scl, driven by the host only
	output logic      sda_low_o  // 1 = pull sda low
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// ****************************************
	// bit level, 6 clk low and 6 clk high
	// ****************************************
	// data moves mid low phase, sampled mid high phase, clear of target delays
	task automatic bit_x(input logic b, output logic s);
		scl_o <= 1'b0;
		wt(3);
		sda_low_o <= ~b;
		wt(3);
		scl_o <= 1'b1;
		wt(3);
		s = sda_i;
		wt(3);
	endtask
	// serves as first and repeated start alike
	task automatic start();
		scl_o <= 1'b0;
		wt(3);
		sda_low_o <= 1'b0;
		wt(3);
		scl_o <= 1'b1;
		wt(6);
		sda_low_o <= 1'b1;
		wt(6);
	endtask
	task automatic stop();
		scl_o <= 1'b0;
		wt(3);
		sda_low_o <= 1'b1;
		wt(3);
		scl_o <= 1'b1;
		wt(6);
		sda_low_o <= 1'b0;
		wt(6);
	endtask
	task automatic byte_x(input logic [7:0] d, input logic a_in, output logic [7:0] q,
		output logic a_out);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
			q[i] = s;
		end
		bit_x(a_in, a_out);
	endtask
	// ****************************************
	// transfers
	// ****************************************
	task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic       k0, k1, k2;
		start();
		byte_x({a, 1'b0}, 1'b1, q, k0);
		byte_x(o, 1'b1, q, k1);
		byte_x(d, 1'b1, q, k2);
		stop();
		ok = ~(k0 | k1 | k2);
	endtask
	// low byte first; the last byte is refused so the target lets go
	task automatic rd(input logic [6:0] a, input logic [7:0] o, input logic two,
		output logic [15:0] v);
		logic [7:0] q;
		logic       k;
		v = 16'h0000;
		start();
		byte_x({a, 1'b0}, 1'b1, q, k);
		byte_x(o, 1'b1, q, k);
		start();
		byte_x({a, 1'b1}, 1'b1, q, k);
		byte_x(8'hFF, ~two, q, k);
		v[7:0] = q;
		if (two) begin
			byte_x(8'hFF, 1'b1, q, k);
			v[15:8] = q;
		end
		stop();
	endtask
endmodule

/* File: sim/slm_monitor_test.sv */
// self-checking bench for the supply-loss monitor
`timescale 1ns/1ps
module slm_monitor_test;
	import slm_pkg::*;
	logic        clk_i;
	logic        resetn_i;
	logic [15:0] supply_mv_i;
	logic        scl, host_low, sda_o, sda_oen_o, batt_on_o, batt_conn_o;
	logic        host_pwr_o, rtc_run_o, periph_en_o, watching_o, ok;
	int          fail_count, compares, cyc, n, g, d;
	logic [31:0] rs;
	logic [15:0] v, t, s;
	// sda has a pull-up: high unless someone pulls it down
	wire         sda_w = ~(host_low | ~sda_oen_o);
	wire  [15:0] outs = {10'h000, batt_on_o, batt_conn_o, host_pwr_o, rtc_run_o,
		periph_en_o, watching_o};

	slm_monitor i_slm_monitor (.clk_i(clk_i), .resetn_i(resetn_i), .supply_mv_i(supply_mv_i),
		.scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oen_o(sda_oen_o),
		.batt_on_o(batt_on_o), .batt_conn_o(batt_conn_o), .host_pwr_o(host_pwr_o),
		.rtc_run_o(rtc_run_o), .periph_en_o(periph_en_o), .watching_o(watching_o));
	slm_i2c_host i_slm_i2c_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
		.sda_low_o(host_low));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [15:0] thr(input int c);
		case (c)
			1: return 16'h1336;
			2: return 16'h1225;
			3: return 16'h1114;
			default: return 16'h1000;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] got);
		compares++;
		if (got !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, got);
			fail_count++;
		end
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// monitor reacts on the next edge, three edges leave margin
	task automatic sup(input logic [15:0] m);
		supply_mv_i <= m;
		wt(3);
	endtask
	task automatic setreg(input logic [7:0] o, input logic [7:0] dat);
		i_slm_i2c_host.wr(7'h6B, o, dat, ok);
		chk("write ack", 16'h0001, {15'h0000, ok});
	endtask
	task automatic conclude();
		$display("counts: %0d compares, %0d mismatches", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial clk_i = 1'b0;
	always #2 clk_i = ~clk_i;
	// whole run needs about 20k cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		rs = 32'h0000D652;
		resetn_i = 1'b0;
		supply_mv_i = 16'h1388;
		wt(2);
		resetn_i <= 1'b1;
		wt(3);
		// ****************************************
		// reset state, register defaults, addressing
		// ****************************************
		chk("outputs after reset", 16'h001E, outs);
		i_slm_i2c_host.rd(7'h6B, 8'h1A, 1'b0, v);
		chk("gap duration", 16'h0019, v);
		i_slm_i2c_host.rd(7'h6B, 8'h1B, 1'b0, v);
		chk("select", 16'h0002, v);
		i_slm_i2c_host.rd(7'h6B, 8'h1C, 1'b0, v);
		chk("drop", 16'h0003, v);
		i_slm_i2c_host.wr(7'h55, 8'h1C, 8'h07, ok);
		chk("foreign address refused", 16'h0000, {15'h0000, ok});
		i_slm_i2c_host.wr(7'h69, 8'h02, 8'h55, ok);
		chk("monitor bank ack", 16'h0001, {15'h0000, ok});
		i_slm_i2c_host.rd(7'h69, 8'h02, 1'b1, v);
		chk("trip word read-only", 16'h0000, v);
		chk("sda drive level", 16'h0000, {15'h0000, sda_o});
		$display("test reset done");
		// ****************************************
		// every threshold code, trip capture
		// ****************************************
		for (int c = 1; c <= 5; c++) begin
			setreg(8'h1B, 8'(c));
			t = thr(c);
			sup(t + 16'(rnd() % 500));
			chk("idle above threshold", 16'h0000, outs & 16'h0021);
			sup(t);
			chk("idle at threshold", 16'h0000, {15'h0000, watching_o});
			s = t - 16'h0001 - 16'(rnd() % 50);
			sup(s);
			chk("watch below threshold", 16'h0001, outs & 16'h0021);
			i_slm_i2c_host.rd(7'h69, 8'h02, 1'b1, v);
			chk("trip word", s / 16'h000A, v);
			sup(16'h1388);
			chk("recovered", 16'h0000, outs & 16'h0021);
		end
		$display("test thresholds done");
		// ****************************************
		// extra drop, boundary and switch capture
		// ****************************************
		setreg(8'h1A, 8'hFF);
		setreg(8'h1B, 8'h02);
		t = 16'h1225;
		for (int k = 0; k < 3; k++) begin
			d = (k == 0) ? 1 : (k == 1) ? 9 : 1 + int'(rnd() % 9);
			setreg(8'h1C, 8'(d));
			i_slm_i2c_host.rd(7'h6B, 8'h1C, 1'b0, v);
			chk("drop readback", 16'(d), v);
			sup(t - 16'h0001);
			sup(t - 16'(d * 100));
			chk("no switch at drop edge", 16'h0001, outs & 16'h0021);
			s = t - 16'(d * 100) - 16'h0001;
			sup(s);
			chk("switch past drop", 16'h0020, outs & 16'h0021);
			i_slm_i2c_host.rd(7'h69, 8'h04, 1'b1, v);
			chk("switch word", s / 16'h000A, v);
			i_slm_i2c_host.rd(7'h69, 8'h02, 1'b1, v);
			chk("trip word kept", (t - 16'h0001) / 16'h000A, v);
			sup(16'h1388);
			chk("back on cable", 16'h0000, outs & 16'h0021);
		end
		$display("test drop done");
		// ****************************************
		// gap window: short gap rejected, long gap switches
		// ****************************************
		g = 1 + int'(rnd() % 2);
		setreg(8'h1A, 8'(g));
		setreg(8'h1C, 8'h09);
		sup(t - 16'h0010);
		wt(2000);
		chk("short gap filtered", 16'h0001, outs & 16'h0021);
		sup(16'h1388);
		chk("short gap rejected", 16'h0000, outs & 16'h0021);
		supply_mv_i <= t - 16'h0010;
		n = 0;
		while (batt_on_o !== 1'b1 && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		ok = (n >= g * 2500) && (n <= g * 2500 + 4);
		chk("window length", 16'h0001, {15'h0000, ok});
		sup(16'h1388);
		$display("test gap window done");
		// ****************************************
		// backup disabled
		// ****************************************
		setreg(8'h1B, 8'h00);
		wt(2);
		chk("disabled on cable", 16'h000A, outs);
		sup(16'h0FA0);
		chk("disabled cable lost", 16'h0002, outs);
		sup(16'h1388);
		setreg(8'h1B, 8'h02);
		wt(2);
		chk("enabled again", 16'h001E, outs);
		$display("test disable done");
		conclude();
	end
endmodule
